// ### rtl/krmc_top.sv
`timescale 1ns/100ps
`include "krmc_params.svh"

module krmc_top #(
    parameter int CTR_W = 32,
    parameter int KEY_CHARS = `KRMC_KEY_CHARS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] utcSeconds,
    input wire logic txReq,
    output logic txAck,
    output logic txEncrypt,
    output logic [KEY_CHARS*4-1:0] txKey,
    output logic [CTR_W-1:0] txCounter
);
    localparam int KW = KEY_CHARS * 4;

    // Parser and bus decode
    logic [KW-1:0] parsedKey;
    logic keyOk;
    logic keyBad;
    logic armed;
    logic next_armed;
    logic setup;
    logic access;
    logic mapped;
    logic wrEn;
    logic ctrlWr;
    logic cmdWr;
    logic charWr;
    logic rotWr;
    logic ctrWr;
    logic applyAct;
    logic applyPnd;
    logic removeCmd;
    logic clearCmd;
    logic rotateNow;
    logic [31:0] next_prdata;

    // Key and counter state
    logic [KW-1:0] activeKey;
    logic [KW-1:0] pendingKey;
    logic activeValid;
    logic pendingValid;
    logic encEn;
    logic [31:0] rotTime;
    logic [CTR_W-1:0] msgCounter;
    logic [KW-1:0] next_activeKey;
    logic [KW-1:0] next_pendingKey;
    logic next_activeValid;
    logic next_pendingValid;
    logic next_encEn;
    logic [31:0] next_rotTime;
    logic [CTR_W-1:0] next_msgCounter;
    logic [CTR_W-1:0] next_txCounter;
    logic [KW-1:0] next_txKey;
    logic next_txAck;
    logic next_txEncrypt;

    // APB phases; one wait-free access after a captured setup
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign pready = access && armed && ce;
    assign mapped = (paddr == `KRMC_OFS_CTRL) || (paddr == `KRMC_OFS_CMD) ||
        (paddr == `KRMC_OFS_STATUS) || (paddr == `KRMC_OFS_KEYCHAR) ||
        (paddr == `KRMC_OFS_ROTTIME) || (paddr == `KRMC_OFS_MSGCTR);
    assign pslverr = pready && !mapped;
    assign wrEn = pready && pwrite && mapped;

    // Write strobes per register
    assign ctrlWr = wrEn && (paddr == `KRMC_OFS_CTRL);
    assign cmdWr = wrEn && (paddr == `KRMC_OFS_CMD);
    assign charWr = wrEn && (paddr == `KRMC_OFS_KEYCHAR);
    assign rotWr = wrEn && (paddr == `KRMC_OFS_ROTTIME);
    assign ctrWr = wrEn && (paddr == `KRMC_OFS_MSGCTR);

    // Commands; a malformed key is silently not applied
    assign applyAct = cmdWr && pwdata[`KRMC_CMD_APPLY_ACT] && keyOk;
    assign applyPnd = cmdWr && pwdata[`KRMC_CMD_APPLY_PND] && keyOk;
    assign removeCmd = cmdWr && pwdata[`KRMC_CMD_REMOVE];
    assign clearCmd = cmdWr && (pwdata[`KRMC_CMD_CLEAR] || applyAct || applyPnd);
    assign rotateNow = pendingValid && (utcSeconds > rotTime);

    krmc_key_hex #(
        .KEY_CHARS(KEY_CHARS)
    ) u_key_hex (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .charValid(charWr),
        .charData(pwdata[7:0]),
        .clear(clearCmd),
        .key(parsedKey),
        .keyOk(keyOk),
        .keyBad(keyBad)
    );

    // Read data is captured at setup so it is steady in access
    always_comb begin
        next_armed = armed;
        next_prdata = prdata;
        if (setup || (access && !armed)) begin
            next_armed = 1'b1; // A setup frozen by ce is caught up here, else the access would hang
            next_prdata = 32'h0000_0000;
            unique case (paddr)
                `KRMC_OFS_CTRL: next_prdata[`KRMC_CTRL_ENC] = encEn;
                `KRMC_OFS_STATUS: begin
                    next_prdata[`KRMC_ST_ACT] = activeValid;
                    next_prdata[`KRMC_ST_PND] = pendingValid;
                    next_prdata[`KRMC_ST_ENC] = encEn;
                    next_prdata[`KRMC_ST_KEYOK] = keyOk;
                    next_prdata[`KRMC_ST_KEYBAD] = keyBad;
                end
                `KRMC_OFS_ROTTIME: next_prdata = rotTime;
                `KRMC_OFS_MSGCTR: next_prdata[CTR_W-1:0] = msgCounter;
                default: next_prdata = 32'h0000_0000;
            endcase
        end else if (pready) begin
            next_armed = 1'b0;
        end
    end

    // Bus registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            armed <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            armed <= next_armed;
            prdata <= next_prdata;
        end
    end

    // Keys, rotation and enable; remove beats apply beats rotation
    always_comb begin
        next_activeKey = activeKey;
        next_pendingKey = pendingKey;
        next_activeValid = activeValid;
        next_pendingValid = pendingValid;
        next_encEn = encEn;
        next_rotTime = rotWr ? pwdata : rotTime;
        if (removeCmd) begin
            next_activeKey = '0;
            next_pendingKey = '0;
            next_activeValid = 1'b0;
            next_pendingValid = 1'b0;
            next_encEn = 1'b0;
        end else begin
            if (applyAct) begin
                next_activeKey = parsedKey;
                next_activeValid = 1'b1;
            end
            if (applyPnd) begin
                next_pendingKey = parsedKey;
                next_pendingValid = 1'b1;
            end
            if (rotateNow && !applyAct && !applyPnd) begin
                next_activeKey = pendingKey;
                next_activeValid = 1'b1;
                next_pendingKey = '0;
                next_pendingValid = 1'b0;
            end
            if (ctrlWr) begin
                // Clearing is always allowed; setting needs a key
                next_encEn = pwdata[`KRMC_CTRL_ENC] && activeValid;
            end
        end
    end

    // Counter: apply resets, then software write, then traffic
    always_comb begin
        next_msgCounter = msgCounter;
        next_txAck = 1'b0;
        next_txEncrypt = txEncrypt;
        next_txKey = txKey;
        next_txCounter = txCounter;
        if (txReq) begin
            next_txAck = 1'b1;
            next_txEncrypt = encEn;
            next_txKey = encEn ? activeKey : '0;
            next_txCounter = msgCounter;
            if (encEn) begin
                next_msgCounter = CTR_W'(msgCounter + 1'b1);
            end
        end
        if (ctrWr) begin
            next_msgCounter = pwdata[CTR_W-1:0];
        end
        if (applyAct || applyPnd) begin
            next_msgCounter = CTR_W'(`KRMC_RST_CTR);
        end
    end

    // Key and counter registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            activeKey <= '0;
            pendingKey <= '0;
            activeValid <= 1'b0;
            pendingValid <= 1'b0;
            encEn <= 1'b0;
            rotTime <= `KRMC_RST_ROT;
            msgCounter <= CTR_W'(`KRMC_RST_CTR);
            txAck <= 1'b0;
            txEncrypt <= 1'b0;
            txKey <= '0;
            txCounter <= '0;
        end else if (ce) begin
            activeKey <= next_activeKey;
            pendingKey <= next_pendingKey;
            activeValid <= next_activeValid;
            pendingValid <= next_pendingValid;
            encEn <= next_encEn;
            rotTime <= next_rotTime;
            msgCounter <= next_msgCounter;
            txAck <= next_txAck;
            txEncrypt <= next_txEncrypt;
            txKey <= next_txKey;
            txCounter <= next_txCounter;
        end
    end

    // Enable never stands without an active key
    property p_enable_needs_key;
        @(posedge clk) disable iff (!rst_n)
        encEn |-> activeValid;
    endproperty
    a_enable_needs_key: assert property (p_enable_needs_key)
        else $error("encryption enabled without active key");

    // A refused set leaves encryption off
    property p_enable_refused;
        @(posedge clk) disable iff (!rst_n)
        (ce && ctrlWr && !activeValid) |=> !encEn;
    endproperty
    a_enable_refused: assert property (p_enable_refused)
        else $error("enable accepted with no key");

    // Applying a key keeps the enable as it was
    property p_apply_keeps_enable;
        @(posedge clk) disable iff (!rst_n)
        (ce && (applyAct || applyPnd) && !removeCmd) |=> (encEn == $past(encEn));
    endproperty
    a_apply_keeps_enable: assert property (p_apply_keeps_enable)
        else $error("key apply changed encryption enable");

    // A malformed key changes no key state
    property p_bad_key_refused;
        @(posedge clk) disable iff (!rst_n)
        (ce && cmdWr && !keyOk && !removeCmd && !rotateNow) |=>
            (activeKey == $past(activeKey)) && (pendingValid == $past(pendingValid));
    endproperty
    a_bad_key_refused: assert property (p_bad_key_refused)
        else $error("malformed key was applied");

    // Rotation moves the pending key into the active slot
    property p_rotate;
        @(posedge clk) disable iff (!rst_n)
        (ce && rotateNow && !cmdWr) |=>
            (activeKey == $past(pendingKey)) && activeValid && !pendingValid;
    endproperty
    a_rotate: assert property (p_rotate)
        else $error("pending key not rotated in");

    // No pending key means the active key holds
    property p_no_pending_no_rotate;
        @(posedge clk) disable iff (!rst_n)
        (ce && !pendingValid && !cmdWr) |=> (activeKey == $past(activeKey));
    endproperty
    a_no_pending_no_rotate: assert property (p_no_pending_no_rotate)
        else $error("active key changed without pending key");

    // Status read shows key presence
    property p_status_read;
        @(posedge clk) disable iff (!rst_n)
        (ce && setup && paddr == `KRMC_OFS_STATUS) |=>
            (prdata[`KRMC_ST_PND:`KRMC_ST_ACT] == {$past(pendingValid), $past(activeValid)});
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status does not show key presence");

    // Key register always reads zero
    property p_key_hidden;
        @(posedge clk) disable iff (!rst_n)
        (ce && setup && paddr == `KRMC_OFS_KEYCHAR) |=> (prdata == 32'h0000_0000);
    endproperty
    a_key_hidden: assert property (p_key_hidden)
        else $error("key material visible on read");

    // Each encrypted send carries the counter, then it steps
    property p_tx_counter;
        @(posedge clk) disable iff (!rst_n)
        (ce && txReq && encEn && !ctrWr && !cmdWr) |=>
            txAck && txEncrypt && (txCounter == $past(msgCounter)) &&
            (msgCounter == CTR_W'($past(msgCounter) + 1'b1));
    endproperty
    a_tx_counter: assert property (p_tx_counter)
        else $error("encrypted send counter wrong");

    // Two encrypted sends in a row carry rising values
    property p_tx_rising;
        @(posedge clk) disable iff (!rst_n)
        (ce && txReq && encEn && !ctrWr && !cmdWr) ##1
            (ce && txReq && encEn && !ctrWr && !cmdWr) |=>
            (txCounter == CTR_W'($past(txCounter) + 1'b1));
    endproperty
    a_tx_rising: assert property (p_tx_rising)
        else $error("counter not rising between sends");

    // Software write of the counter lands
    property p_counter_write;
        @(posedge clk) disable iff (!rst_n)
        (ce && ctrWr) |=> (msgCounter == $past(pwdata[CTR_W-1:0]));
    endproperty
    a_counter_write: assert property (p_counter_write)
        else $error("counter write lost");

    // Any applied key zeroes the counter
    property p_apply_zero;
        @(posedge clk) disable iff (!rst_n)
        (ce && (applyAct || applyPnd)) |=> (msgCounter == '0);
    endproperty
    a_apply_zero: assert property (p_apply_zero)
        else $error("counter not zeroed on key apply");

    // Remove clears every key and the enable
    property p_remove;
        @(posedge clk) disable iff (!rst_n)
        (ce && removeCmd) |=> !activeValid && !pendingValid && !encEn;
    endproperty
    a_remove: assert property (p_remove)
        else $error("remove left key or enable behind");
endmodule // krmc_top

// ### inc/krmc_params.svh
`ifndef KRMC_PARAMS_SVH
`define KRMC_PARAMS_SVH

// Register byte offsets
`define KRMC_OFS_CTRL 8'h00
`define KRMC_OFS_CMD 8'h04
`define KRMC_OFS_STATUS 8'h08
`define KRMC_OFS_KEYCHAR 8'h0c
`define KRMC_OFS_ROTTIME 8'h10
`define KRMC_OFS_MSGCTR 8'h14

// Control and command bit positions
`define KRMC_CTRL_ENC 0
`define KRMC_CMD_APPLY_ACT 0
`define KRMC_CMD_APPLY_PND 1
`define KRMC_CMD_REMOVE 2
`define KRMC_CMD_CLEAR 3

// Status bit positions
`define KRMC_ST_ACT 0
`define KRMC_ST_PND 1
`define KRMC_ST_ENC 2
`define KRMC_ST_KEYOK 3
`define KRMC_ST_KEYBAD 4

// Reset values
`define KRMC_RST_CTR 32'h0000_0000
`define KRMC_RST_ROT 32'h0000_0000

// Key text format
`define KRMC_KEY_CHARS 32
`define KRMC_KEY_BITS 128
`define KRMC_CHAR_COLON 8'h3a

`endif

// ### inc/krmc_pkg.sv
package krmc_pkg;
    // Key text parser position
    typedef enum {
        HX_HI,
        HX_LO,
        HX_PAIR,
        HX_FULL,
        HX_BAD
    } krmc_hex_e;
    typedef logic [7:0] krmc_char_t;
endpackage

// ### rtl/krmc_key_hex.sv
`timescale 1ns/100ps
`include "krmc_params.svh"

module krmc_key_hex #(
    parameter int KEY_CHARS = `KRMC_KEY_CHARS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic charValid,
    input wire krmc_pkg::krmc_char_t charData,
    input wire logic clear,
    output logic [KEY_CHARS*4-1:0] key,
    output logic keyOk,
    output logic keyBad
);
    localparam int PAIRS = KEY_CHARS / 2;

    krmc_pkg::krmc_hex_e state;
    krmc_pkg::krmc_hex_e next_state;
    logic [KEY_CHARS*4-1:0] next_key;
    logic [7:0] pairs;
    logic [7:0] next_pairs;
    logic isHex;
    logic [3:0] nib;

    // ASCII hex digit decode, either case
    always_comb begin
        isHex = 1'b1;
        nib = 4'h0;
        if (charData >= 8'h30 && charData <= 8'h39) begin
            nib = charData[3:0];
        end else if ((charData | 8'h20) >= 8'h61 && (charData | 8'h20) <= 8'h66) begin
            nib = 4'(charData[3:0] + 4'h9);
        end else begin
            isHex = 1'b0;
        end
    end

    // Colons only between complete pairs, never leading or doubled
    always_comb begin
        next_state = state;
        next_key = key;
        next_pairs = pairs;
        if (clear) begin
            next_state = krmc_pkg::HX_HI;
            next_key = '0;
            next_pairs = 8'h00;
        end else if (charValid) begin
            unique case (state)
                krmc_pkg::HX_HI, krmc_pkg::HX_PAIR: begin
                    if (isHex) begin
                        next_key = {key[KEY_CHARS*4-5:0], nib};
                        next_state = krmc_pkg::HX_LO;
                    end else if (charData == `KRMC_CHAR_COLON && state == krmc_pkg::HX_PAIR) begin
                        next_state = krmc_pkg::HX_HI;
                    end else begin
                        next_state = krmc_pkg::HX_BAD;
                    end
                end
                krmc_pkg::HX_LO: begin
                    if (isHex) begin
                        next_key = {key[KEY_CHARS*4-5:0], nib};
                        next_pairs = 8'(pairs + 8'h01);
                        next_state = (pairs == 8'(PAIRS - 1)) ? krmc_pkg::HX_FULL : krmc_pkg::HX_PAIR;
                    end else begin
                        next_state = krmc_pkg::HX_BAD;
                    end
                end
                krmc_pkg::HX_FULL, krmc_pkg::HX_BAD: begin
                    next_state = krmc_pkg::HX_BAD; // Extra characters spoil the key
                end
            endcase
        end
    end

    // Parser registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= krmc_pkg::HX_HI;
            key <= '0;
            pairs <= 8'h00;
        end else if (ce) begin
            state <= next_state;
            key <= next_key;
            pairs <= next_pairs;
        end
    end

    assign keyOk = (state == krmc_pkg::HX_FULL);
    assign keyBad = (state == krmc_pkg::HX_BAD);
endmodule // krmc_key_hex

// ### sim/krmc_remote_decoder.sv
`timescale 1ns/100ps

// Far-side decoder for one source address: keeps the highest counter seen
module krmc_remote_decoder #(
    parameter int CTR_W = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic txAck,
    input wire logic txEncrypt,
    input wire logic [CTR_W-1:0] txCounter,
    input wire logic tableClear,
    output logic [15:0] acceptCount,
    output logic [15:0] rejectCount
);
    logic seen;
    logic [CTR_W-1:0] highest;

    // Replay filter; a new key needs tableClear, or counter zero looks like a replay
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            seen <= 1'b0;
            highest <= '0;
            acceptCount <= 16'h0;
            rejectCount <= 16'h0;
        end else if (tableClear) begin
            seen <= 1'b0;
            highest <= '0;
        end else if (txAck && txEncrypt) begin
            if (!seen || txCounter > highest) begin
                seen <= 1'b1;
                highest <= txCounter;
                acceptCount <= acceptCount + 16'h1;
            end else begin
                rejectCount <= rejectCount + 16'h1;
            end
        end
    end
endmodule // krmc_remote_decoder

// ### sim/testbench.sv
`timescale 1ns/100ps
`include "krmc_params.svh"

module testbench;
    logic clk, rst_n, ce, psel, penable, pwrite, pready, pslverr, txReq, txAck, txEncrypt, tableClear;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, utcSeconds, txCounter;
    logic [127:0] txKey;
    logic [15:0] acceptCount, rejectCount;
    int errCount = 0;
    int testsRun = 0;
    localparam logic [127:0] KEY_A = 128'h0123456789abcdeffedcba9876543210;
    localparam logic [127:0] KEY_B = 128'h00112233445566778899aabbccddeeff;

    krmc_top dut (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .utcSeconds(utcSeconds), .txReq(txReq), .txAck(txAck), .txEncrypt(txEncrypt), .txKey(txKey),
        .txCounter(txCounter));
    krmc_remote_decoder decoder (.clk(clk), .rst_n(rst_n), .txAck(txAck), .txEncrypt(txEncrypt),
        .txCounter(txCounter), .tableClear(tableClear), .acceptCount(acceptCount), .rejectCount(rejectCount));

    // Free-running 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
        testsRun++;
        if (got !== exp) begin
            errCount++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One APB transfer; pready, read data and error are all taken at the same rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
            output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) chk(1'b0, 1'b1, "pready never came");
        e = pslverr;
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp, what);
    endtask

    // Key text goes one character per write
    task automatic sendKey(input string s);
        for (int i = 0; i < s.len(); i++) wr(`KRMC_OFS_KEYCHAR, {24'h0, s[i]});
    endtask

    // One transmission; counter is judged only on encrypted sends
    task automatic sendChk(input logic enc, input logic [127:0] key, input logic [31:0] ctr);
        @(posedge clk);
        txReq <= 1'b1;
        @(posedge clk);
        txReq <= 1'b0;
        @(negedge clk);
        chk(txAck, 1'b1, "tx ack");
        chk(txEncrypt, enc, "tx encrypt flag");
        chk(txKey, key, "tx key");
        if (enc) chk(txCounter, ctr, "tx counter");
    endtask

    // Two sends on consecutive edges; the second must carry the next value
    task automatic sendTwoChk(input logic [127:0] key, input logic [31:0] ctr);
        @(posedge clk);
        txReq <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk(txCounter, ctr, "first of pair");
        @(posedge clk);
        txReq <= 1'b0;
        @(negedge clk);
        chk(txAck, 1'b1, "second of pair ack");
        chk(txKey, key, "second of pair key");
        chk(txCounter, ctr + 32'h1, "second of pair counter");
    endtask

    task automatic t_reset_refuse;
        logic [31:0] r;
        logic e;
        rdChk(`KRMC_OFS_STATUS, 32'h0, "status after reset");
        rdChk(`KRMC_OFS_MSGCTR, `KRMC_RST_CTR, "counter after reset");
        wr(`KRMC_OFS_CTRL, 32'h1);
        rdChk(`KRMC_OFS_CTRL, 32'h0, "enable without key");
        rdChk(`KRMC_OFS_STATUS, 32'h0, "status enable without key");
        apb(1'b0, 8'h18, 32'h0, r, e);
        chk(e, 1'b1, "unmapped error");
        chk(r, 32'h0, "unmapped data");
        $display("test reset_refuse done");
    endtask

    task automatic t_key_entry;
        sendKey("00112233445566778899AABBCCDDEEFF");
        wr(`KRMC_OFS_KEYCHAR, 32'h35);
        rdChk(`KRMC_OFS_STATUS, 32'h10, "char after 32nd");
        wr(`KRMC_OFS_CMD, 32'h8);
        wr(`KRMC_OFS_KEYCHAR, {24'h0, `KRMC_CHAR_COLON});
        rdChk(`KRMC_OFS_STATUS, 32'h10, "leading colon");
        wr(`KRMC_OFS_CMD, 32'h8);
        rdChk(`KRMC_OFS_STATUS, 32'h0, "parser cleared");
        sendKey("01:23:45:67:89:ab:cd:ef:fe:dc:ba:98:76:54:32:10");
        rdChk(`KRMC_OFS_STATUS, 32'h08, "colon key complete");
        wr(`KRMC_OFS_CMD, 32'h1);
        rdChk(`KRMC_OFS_STATUS, 32'h01, "active loaded, no enable");
        rdChk(`KRMC_OFS_CTRL, 32'h0, "enable still off");
        rdChk(`KRMC_OFS_KEYCHAR, 32'h0, "key not readable");
        rdChk(`KRMC_OFS_CMD, 32'h0, "command not readable");
        sendChk(1'b0, 128'h0, 32'h0);
        $display("test key_entry done");
    endtask

    task automatic t_counter;
        wr(`KRMC_OFS_MSGCTR, 32'h7);
        wr(`KRMC_OFS_CTRL, 32'h1);
        rdChk(`KRMC_OFS_STATUS, 32'h05, "enable with key");
        for (int i = 0; i < 3; i++) sendChk(1'b1, KEY_A, 32'h7 + i);
        rdChk(`KRMC_OFS_MSGCTR, 32'ha, "counter after sends");
        chk(acceptCount, 16'h3, "decoder accepted");
        wr(`KRMC_OFS_MSGCTR, 32'h8);
        sendChk(1'b1, KEY_A, 32'h8);
        @(negedge clk);
        chk(rejectCount, 16'h1, "decoder rejected replay");
        // A send while ce is low must leave no trace
        @(posedge clk);
        ce <= 1'b0;
        txReq <= 1'b1;
        @(posedge clk);
        ce <= 1'b1;
        txReq <= 1'b0;
        @(negedge clk);
        chk(txAck, 1'b0, "no ack while frozen");
        chk(txCounter, 32'h8, "tx counter frozen");
        rdChk(`KRMC_OFS_MSGCTR, 32'h9, "counter frozen by ce");
        $display("test counter done");
    endtask

    task automatic t_rotation;
        @(posedge clk);
        utcSeconds <= 32'd100;
        wr(`KRMC_OFS_ROTTIME, 32'd100);
        sendKey("00112233445566778899AABBCCDDEEFF");
        wr(`KRMC_OFS_CMD, 32'h2);
        rdChk(`KRMC_OFS_MSGCTR, 32'h0, "counter after pending apply");
        rdChk(`KRMC_OFS_STATUS, 32'h07, "pending held at equal time");
        @(posedge clk);
        utcSeconds <= 32'd101;
        repeat (3) @(posedge clk);
        rdChk(`KRMC_OFS_STATUS, 32'h05, "pending promoted");
        @(posedge clk);
        tableClear <= 1'b1;
        @(posedge clk);
        tableClear <= 1'b0;
        sendChk(1'b1, KEY_B, 32'h0);
        sendTwoChk(KEY_B, 32'h1);
        @(negedge clk);
        chk(acceptCount, 16'h6, "decoder accepted pair");
        $display("test rotation done");
    endtask

    task automatic t_remove;
        wr(`KRMC_OFS_CMD, 32'h4);
        rdChk(`KRMC_OFS_STATUS, 32'h0, "keys removed");
        rdChk(`KRMC_OFS_CTRL, 32'h0, "enable forced off");
        sendChk(1'b0, 128'h0, 32'h0);
        $display("test remove done");
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", testsRun, errCount);
        if (errCount == 0 && testsRun > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Main sequence; ce stays high except for the one cycle that t_counter drops it to freeze a send
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        utcSeconds = 32'd500;
        txReq = 1'b0;
        tableClear = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_refuse();
        t_key_entry();
        t_counter();
        t_rotation();
        t_remove();
        print_verdict();
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        errCount++;
        $display("BAD %0t watchdog expired", $time);
        print_verdict();
    end
endmodule // testbench
